/* File: phy100_pkg.sv */
// Shared constants and types for the 100BASE-TX transmit line path and receive front end.
// Assumes one clock that ticks once per transmit line bit; the receive input is oversampled.
//
// Behaviour
// - Split NRZI stream into two binary phase streams with alternating one events.
// - Drive both phase streams to the shared 100/1000 converter and line driver.
// - Transmit output carries only three-level symbols; no plain binary mode exists.
// - With transmit error and enable both high, send HALT instead of data groups.
// - Start and end delimiter pairs stay unchanged while errors are substituted.
// - Fast link pulse bursts never assert the receive signal-detect indication.
// - Received three-level stream is packed into 4-bit nibbles toward the MAC.
// - Digital phase-locked loop recovers the receive symbol clock from equalizer output.
// - HALT code-group is the 5-bit pattern 00100.
// - First two preamble nibbles become the start pair 11000 then 10001.
// - On transmit enable falling, send end pair 01101 then 00111.
// - After the end pair, send idle groups until transmit enable returns.

package phy100_pkg;

    // ------------------------------------------------------------------
    // Code-groups
    // ------------------------------------------------------------------
    localparam int           CG_BITS = 5;
    localparam logic [4:0]   CG_HALT = 5'h04;
    localparam logic [4:0]   CG_IDLE = 5'h1f;
    localparam logic [4:0]   CG_J    = 5'h18;
    localparam logic [4:0]   CG_K    = 5'h11;
    localparam logic [4:0]   CG_T    = 5'h0d;
    localparam logic [4:0]   CG_R    = 5'h07;
    localparam logic [2:0]   CG_LAST = 3'h4;   // Bit index that loads the next group

    // ------------------------------------------------------------------
    // Sizes, counts and reset values
    // ------------------------------------------------------------------
    localparam int           TX_FIFO_DEPTH  = 4;
    localparam int           TX_FIFO_WIDTH  = 6;      // {en, er, nibble}
    localparam int           RX_OVERSAMPLE  = 4;      // Input samples per line symbol
    localparam logic [5:0]   SD_QUIET_MAX   = 6'h10;  // Longest zero run seen in live data
    localparam logic [9:0]   SD_ON_COUNT    = 10'h1f4;// Busy symbols before detect asserts
    localparam logic [1:0]   MLT_RST        = 2'h0;   // Line at zero after reset
    localparam logic [1:0]   MLT_PLUS       = 2'h1;
    localparam logic [1:0]   MLT_MINUS      = 2'h3;

    // ------------------------------------------------------------------
    // Transmit encoder states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_K,
        ST_DATA,
        ST_R
    } tx_state_e;

    // Nibble to 5B data code-group
    function automatic logic [4:0] enc_nibble(input logic [3:0] nib);
        logic [4:0] cg;
        cg = CG_IDLE;
        unique case (nib)
            4'h0: cg = 5'h1e;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0a;
            4'h5: cg = 5'h0b;
            4'h6: cg = 5'h0e;
            4'h7: cg = 5'h0f;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'ha: cg = 5'h16;
            4'hb: cg = 5'h17;
            4'hc: cg = 5'h1a;
            4'hd: cg = 5'h1b;
            4'he: cg = 5'h1c;
            4'hf: cg = 5'h1d;
        endcase
        return cg;
    endfunction

endpackage

/* File: stream_fifo.sv */
// Small valid/ready FIFO with parameterised width and depth.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module stream_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    logic             push;
    logic             pop;

    // ------------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------------
    assign o_in_ready  = (count_q != (PW+1)'(DEPTH));
    assign o_out_valid = (count_q != '0);
    assign o_out_data  = mem_q[rd_ptr_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // Storage write
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_in_data;
        end
    end

    // Pointers wrap at the depth
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    // Occupancy
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
        end
    end

endmodule // stream_fifo

`default_nettype wire

/* File: phy100_line_path.sv */
// 100BASE-TX line path: transmit group encoder with error substitution, NRZI and MLT-3
// phase split; receive DPLL, MLT-3 decode, nibble packing and signal detect.
// Assumes i_mclk ticks once per transmit line bit and the receive decisions arrive at
// RX_OVERSAMPLE samples per symbol, both synchronous to i_mclk.
`timescale 1ns/1ns
`default_nettype none

module phy100_line_path
    import phy100_pkg::*;
#(
    parameter int FIFO_DEPTH = TX_FIFO_DEPTH,
    parameter int OVS        = RX_OVERSAMPLE
) (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // Transmit nibbles from the MAC
    input  wire logic       i_tx_valid,
    output logic            o_tx_ready,
    input  wire logic       i_tx_en,
    input  wire logic       i_tx_er,
    input  wire logic [3:0] i_txd,
    // Transmit phase streams to the shared converter
    output logic            o_tx_line_pair_a_pos,
    output logic            o_tx_line_pair_a_neg,
    // Receive decisions from the equalizer
    input  wire logic       i_rx_line_pair_b_pos,
    input  wire logic       i_rx_line_pair_b_neg,
    // Receive results
    output logic            o_rx_sym_tick,
    output logic [3:0]      o_rxd,
    output logic            o_rx_nibble_valid,
    output logic            o_signal_detect
);

    localparam int PW = (OVS > 1) ? $clog2(OVS) : 1;

    // ------------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------------
    logic       fifo_valid;
    logic [5:0] fifo_data;
    logic       pop;
    logic       ent_en;
    logic       ent_er;
    logic [3:0] ent_nib;

    stream_fifo #(
        .WIDTH (TX_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_in_valid  (i_tx_valid),
        .o_in_ready  (o_tx_ready),
        .i_in_data   ({i_tx_en, i_tx_er, i_txd}),
        .o_out_valid (fifo_valid),
        .i_out_ready (pop),
        .o_out_data  (fifo_data)
    );

    assign ent_en  = fifo_data[5];
    assign ent_er  = fifo_data[4];
    assign ent_nib = fifo_data[3:0];

    // ------------------------------------------------------------------
    // Code-group encoder
    // ------------------------------------------------------------------
    tx_state_e  state_q;
    tx_state_e  state_d;
    logic [4:0] cg_q;
    logic [4:0] cg_d;
    logic [2:0] bit_cnt_q;
    logic       load;
    logic       ent_live;

    assign load     = (bit_cnt_q == CG_LAST);
    assign ent_live = fifo_valid && ent_en;

    // Next group and state, chosen at the last bit of the current group
    always_comb begin
        state_d = state_q;
        cg_d    = CG_IDLE;
        pop     = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                pop = load && fifo_valid;              // Drop gap entries, error bit unused
                if (ent_live) begin
                    cg_d    = CG_J;                    // First preamble nibble
                    state_d = ST_K;
                end else begin
                    cg_d    = CG_IDLE;                 // Idle between frames
                end
            end
            ST_K: begin
                pop     = load && ent_live;
                cg_d    = CG_K;                        // Second preamble nibble
                state_d = ST_DATA;
            end
            ST_DATA: begin
                if (ent_live) begin
                    pop  = load;
                    cg_d = ent_er ? CG_HALT : enc_nibble(ent_nib);
                end else begin
                    cg_d    = CG_T;                    // Enable fell or stream ran dry
                    state_d = ST_R;
                end
            end
            ST_R: begin
                cg_d    = CG_R;
                state_d = ST_IDLE;
            end
        endcase
    end

    // State and group register
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            cg_q    <= CG_IDLE;
        end else if (load) begin
            state_q <= state_d;
            cg_q    <= cg_d;
        end else begin
            cg_q    <= {cg_q[3:0], 1'b0};              // Most significant bit leaves first
        end
    end

    // Bit counter, one group every five clocks
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            bit_cnt_q <= '0;
        end else begin
            bit_cnt_q <= load ? 3'h0 : bit_cnt_q + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // NRZI and MLT-3 phase split
    // ------------------------------------------------------------------
    logic       nrzi_q;
    logic       nrzi_prev_q;
    logic [1:0] mlt_q;

    // NRZI toggles on every one bit
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            nrzi_q      <= 1'b0;
            nrzi_prev_q <= 1'b0;
        end else begin
            nrzi_q      <= nrzi_q ^ cg_q[4];
            nrzi_prev_q <= nrzi_q;
        end
    end

    // Each NRZI transition steps the line through 0, +, 0, -
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            mlt_q <= MLT_RST;
        end else if (nrzi_q != nrzi_prev_q) begin
            mlt_q <= mlt_q + 2'h1;
        end
    end

    // Only three-level phase pulses reach the driver
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_tx_line_pair_a_pos <= 1'b0;
            o_tx_line_pair_a_neg <= 1'b0;
        end else begin
            o_tx_line_pair_a_pos <= (mlt_q == MLT_PLUS);
            o_tx_line_pair_a_neg <= (mlt_q == MLT_MINUS);
        end
    end

    // ------------------------------------------------------------------
    // Receive digital PLL
    // ------------------------------------------------------------------
    logic [1:0]    lvl_in;
    logic [1:0]    lvl_prev_q;
    logic [PW-1:0] phase_q;
    logic          edge_seen;
    logic          strobe;

    assign lvl_in    = {i_rx_line_pair_b_pos, i_rx_line_pair_b_neg};
    assign edge_seen = (lvl_in != lvl_prev_q);
    assign strobe    = (phase_q == PW'(OVS/2));

    // Phase counter realigns on every level change, sampling mid-symbol
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            lvl_prev_q <= 2'h0;
            phase_q    <= '0;
        end else begin
            lvl_prev_q <= lvl_in;
            if (edge_seen) begin
                phase_q <= PW'(1);
            end else begin
                phase_q <= (phase_q == PW'(OVS-1)) ? '0 : phase_q + 1'b1;
            end
        end
    end

    // Recovered symbol clock enable
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rx_sym_tick <= 1'b0;
        end else begin
            o_rx_sym_tick <= strobe;
        end
    end

    // ------------------------------------------------------------------
    // MLT-3 decode and nibble packing
    // ------------------------------------------------------------------
    logic [1:0] sym_q;
    logic [2:0] shf_q;
    logic [1:0] rx_cnt_q;
    logic       rx_bit;

    assign rx_bit = (lvl_in != sym_q);                 // Level change carries a one

    // Symbol register and packing, first bit in the low position
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sym_q             <= 2'h0;
            shf_q             <= 3'h0;
            rx_cnt_q          <= 2'h0;
            o_rxd             <= 4'h0;
            o_rx_nibble_valid <= 1'b0;
        end else begin
            o_rx_nibble_valid <= 1'b0;
            if (strobe) begin
                sym_q    <= lvl_in;
                rx_cnt_q <= rx_cnt_q + 2'h1;
                if (rx_cnt_q == 2'h3) begin
                    o_rxd             <= {rx_bit, shf_q};
                    o_rx_nibble_valid <= 1'b1;
                end else begin
                    shf_q <= {rx_bit, shf_q[2:1]};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Signal detect
    // ------------------------------------------------------------------
    logic [5:0] quiet_q;
    logic [9:0] busy_q;
    logic       sym_zero;

    assign sym_zero = (lvl_in == 2'h0) || (lvl_in == 2'h3);

    // Long silences reset the busy count, so sparse link pulses never qualify
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            quiet_q         <= 6'h0;
            busy_q          <= 10'h0;
            o_signal_detect <= 1'b0;
        end else if (strobe) begin
            if (!sym_zero) begin
                quiet_q <= 6'h0;
            end else if (quiet_q != 6'h3f) begin
                quiet_q <= quiet_q + 6'h1;
            end
            if (quiet_q >= SD_QUIET_MAX) begin
                busy_q          <= 10'h0;
                o_signal_detect <= 1'b0;
            end else if (busy_q != SD_ON_COUNT) begin
                busy_q <= busy_q + 10'h1;
            end else begin
                o_signal_detect <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic last_neg_q;

    // Polarity of the most recent line pulse
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            last_neg_q <= 1'b1;
        end else if (o_tx_line_pair_a_pos) begin
            last_neg_q <= 1'b0;
        end else if (o_tx_line_pair_a_neg) begin
            last_neg_q <= 1'b1;
        end
    end

    a_halt_on_error: assert property (@(posedge i_mclk) disable iff (i_rst)
        load && state_q == ST_DATA && ent_live && ent_er |=> cg_q == CG_HALT)
        else $error("error nibble not replaced by HALT");

    a_no_gap_halt: assert property (@(posedge i_mclk) disable iff (i_rst)
        load && state_q == ST_IDLE && !ent_live |=> cg_q == CG_IDLE && state_q == ST_IDLE)
        else $error("gap did not stay idle");

    a_start_pair: assert property (@(posedge i_mclk) disable iff (i_rst)
        load && state_q == ST_IDLE && ent_live |=> cg_q == CG_J ##5 cg_q == CG_K)
        else $error("start pair not sent");

    a_end_pair: assert property (@(posedge i_mclk) disable iff (i_rst)
        load && state_q == ST_DATA && !ent_live |=> cg_q == CG_T ##5 cg_q == CG_R && state_q == ST_IDLE
        ##5 (cg_q == CG_IDLE || cg_q == CG_J))
        else $error("end pair not sent");

    a_group_rate: assert property (@(posedge i_mclk) disable iff (i_rst)
        load |=> !load [*4] ##1 load)
        else $error("group period not five bits");

    a_mlt3_levels: assert property (@(posedge i_mclk) disable iff (i_rst)
        !(o_tx_line_pair_a_pos && o_tx_line_pair_a_neg))
        else $error("both phases driven at once");

    a_mlt3_alternate: assert property (@(posedge i_mclk) disable iff (i_rst)
        $rose(o_tx_line_pair_a_pos) |-> $past(last_neg_q))
        else $error("positive pulse did not follow negative");

    a_dpll_realign: assert property (@(posedge i_mclk) disable iff (i_rst)
        edge_seen |=> phase_q == PW'(1) ##1 !o_rx_sym_tick)
        else $error("phase not realigned on edge");

    a_nibble_pack: assert property (@(posedge i_mclk) disable iff (i_rst)
        strobe && rx_cnt_q == 2'h3 |=> o_rx_nibble_valid ##1 !o_rx_nibble_valid)
        else $error("nibble not produced after four symbols");

    a_pulse_no_detect: assert property (@(posedge i_mclk) disable iff (i_rst)
        strobe && quiet_q >= SD_QUIET_MAX |=> !o_signal_detect && busy_q == 10'h0)
        else $error("signal detect held through silence");

endmodule // phy100_line_path

`default_nettype wire

/* File: mac_model.sv */
// MAC stand-in: queues transmit entries and offers them over valid/ready.
// Assumes the bench fills the queue with push and sets gap for slow pacing.
`timescale 1ns/1ns
`default_nettype none

module mac_model (
    // Clock and reset
    input  wire logic  i_mclk,
    input  wire logic  i_rst,
    // Transmit entries
    output var logic   o_tx_valid,
    input  wire logic  i_tx_ready,
    output var logic   o_tx_en,
    output var logic   o_tx_er,
    output var logic [3:0] o_txd
);
    logic [5:0] q[$];
    int         gap    = 0;
    int         hold_n = 0;

    // ------
    // Queue and offer
    // ------
    // Bench entry point, one {en, er, nibble} entry
    task automatic push(input logic [5:0] ent);
        q.push_back(ent);
    endtask

    // Nothing offered before reset ends
    initial begin
        o_tx_valid = 1'b0;
        {o_tx_en, o_tx_er, o_txd} = 6'h00;
    end

    // Hold an offer until ready is seen, then wait gap cycles
    always @(posedge i_mclk) begin
        if (!i_rst && o_tx_valid && i_tx_ready) begin
            q.delete(0);
            hold_n = gap;
        end else if (hold_n > 0) begin
            hold_n = hold_n - 1;
        end
        if (!i_rst && q.size() > 0 && hold_n == 0) begin
            o_tx_valid <= 1'b1;
            {o_tx_en, o_tx_er, o_txd} <= q[0];
        end else begin
            // Released lines wander so a stale entry is never reused
            o_tx_valid <= 1'b0;
            {o_tx_en, o_tx_er, o_txd} <= ~{o_tx_en, o_tx_er, o_txd};
        end
    end
endmodule // mac_model
`default_nettype wire

/* File: testbench.sv */
// Bench for the 100BASE-TX line path: framed and errored transmit, receive pulses and data.
// Assumes mac_model as the MAC and one 50 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module testbench
    import phy100_pkg::*;
;
    localparam logic [4:0] DATA5B [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    logic       i_mclk = 1'b0;
    logic       i_rst  = 1'b1;
    logic       rx_p   = 1'b0;
    logic       rx_n   = 1'b0;
    logic       tx_valid, tx_ready, tx_en, tx_er, pos, neg, tick, nib_v, sig_det;
    logic [3:0] txd, rxd;
    logic       rxb[$];
    logic       nb[$];
    logic [1:0] lvl_q   = 2'h0;
    logic [1:0] last_nz = 2'h0;
    logic [1:0] rl      = 2'h0;
    int         both_hi = 0, alt_bad = 0, ready_low = 0, ticks = 0, sd_hi = 0;
    int         err_count = 0, tests_run = 0;

    // ------
    // Clock, design, MAC and monitor
    // ------
    initial begin
        forever #10 i_mclk = ~i_mclk;
    end

    phy100_line_path #(.FIFO_DEPTH(TX_FIFO_DEPTH), .OVS(RX_OVERSAMPLE)) dut_u (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
        .i_tx_en(tx_en), .i_tx_er(tx_er), .i_txd(txd), .o_tx_line_pair_a_pos(pos),
        .o_tx_line_pair_a_neg(neg), .i_rx_line_pair_b_pos(rx_p), .i_rx_line_pair_b_neg(rx_n),
        .o_rx_sym_tick(tick), .o_rxd(rxd), .o_rx_nibble_valid(nib_v), .o_signal_detect(sig_det));

    mac_model mac_u (.i_mclk(i_mclk), .i_rst(i_rst), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
        .o_tx_en(tx_en), .o_tx_er(tx_er), .o_txd(txd));

    // Sample settled outputs on the falling edge: line bits, phase order, rx nibbles
    always @(negedge i_mclk) begin
        if (!i_rst) begin
            rxb.push_back({pos, neg} != lvl_q);
            if (pos && neg) both_hi++;
            if ({pos, neg} != lvl_q && (pos || neg)) begin
                if ({pos, neg} == last_nz) alt_bad++;
                last_nz = {pos, neg};
            end
            lvl_q = {pos, neg};
            if (!tx_ready) ready_low++;
            if (tick) ticks++;
            if (sig_det) sd_hi++;
            if (nib_v) for (int k = 0; k < 4; k++) nb.push_back(rxd[k]);
        end
    end

    // ------
    // Shared tasks
    // ------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Five line bits from index i, first bit in the MSB
    function automatic logic [4:0] grp(input int i);
        for (int b = 0; b < 5; b++) grp[4-b] = rxb[i+b];
    endfunction

    function automatic logic [15:0] nbits(input int j);
        for (int k = 0; k < 16; k++) nbits[k] = nb[j+k];
    endfunction

    // Feed entries, let the line settle, then locate the start pair and compare groups
    task automatic run_frame(input logic [5:0] ent[$], input logic [4:0] want[$]);
        int s;
        rxb.delete();
        repeat (20) @(posedge i_mclk);
        foreach (ent[i]) mac_u.push(ent[i]);
        for (int n = 0; mac_u.q.size() > 0; n++) begin
            if (n > 3000) begin
                check("drain wait", 0, 1);
                finish_test();
            end
            @(posedge i_mclk);
        end
        repeat (5 * want.size() + 40) @(posedge i_mclk);
        s = 10;
        while (s + 10 < rxb.size() && {grp(s), grp(s + 5)} !== {CG_J, CG_K}) s++;
        check("idle before start", grp(s - 5), CG_IDLE);
        check("idle with stray error", grp(s - 10), CG_IDLE);
        foreach (want[k]) check("code group", grp(s + 5 * k), want[k]);
    endtask

    // One line symbol: a one steps the level 0, +, 0 (as 11), -
    task automatic sym(input logic b);
        rl = rl + {1'b0, b};
        @(posedge i_mclk);
        rx_p <= (rl == 2'h1) || (rl == 2'h2);
        rx_n <= rl[1];
        repeat (RX_OVERSAMPLE - 1) @(posedge i_mclk);
    endtask

    // ------
    // Scenarios
    // ------
    task automatic frame_normal;
        logic [5:0] ent[$];
        logic [4:0] want[$];
        ent = '{6'h25, 6'h25};
        want = '{CG_J, CG_K};
        for (int i = 0; i < 16; i++) begin
            ent.push_back({2'b10, i[3:0]});
            want.push_back(DATA5B[i]);
        end
        ent.push_back(6'h00);
        want = {want, CG_T, CG_R, CG_IDLE, CG_IDLE};
        run_frame(ent, want);
        check("fifo refused when full", ready_low > 0, 1'b1);
        check("fifo drained", tx_ready, 1'b1);
        check("both phases high", both_hi, 0);
        check("phase alternation", alt_bad, 0);
        $display("frame_normal done");
    endtask

    // Errors on delimiters, data and between frames, with slow pacing
    task automatic frame_error;
        mac_u.gap = 2;
        run_frame('{6'h10, 6'h1f, 6'h15, 6'h35, 6'h35, 6'h23, 6'h37, 6'h30, 6'h29, 6'h10},
                  '{CG_J, CG_K, DATA5B[3], CG_HALT, CG_HALT, DATA5B[9], CG_T, CG_R, CG_IDLE});
        mac_u.gap = 0;
        check("phase alternation", alt_bad, 0);
        $display("frame_error done");
    endtask

    // Link pulse bursts long enough to reach the busy count if quiet were ignored
    task automatic rx_pulses;
        sd_hi = 0;
        for (int p = 0; p < 17; p++) begin
            sym(1'b1);
            sym(1'b1);
            repeat (60) sym(1'b0);
        end
        check("detect on pulses", sd_hi, 0);
        $display("rx_pulses done");
    endtask

    task automatic rx_data;
        int          j;
        logic [15:0] m;
        m = 16'h4c1a;
        repeat (600) sym(1'b1);
        check("detect on data", sig_det, 1'b1);
        ticks = 0;
        repeat (100) sym(1'b1);
        check("symbol ticks", ticks, 100);
        nb.delete();
        for (int i = 0; i < 16; i++) sym(m[i]);
        repeat (12) sym(1'b1);
        j = 0;
        while (j + 16 < nb.size() && nbits(j) !== m) j++;
        check("received bits", nbits(j), m);
        repeat (20) sym(1'b0);
        check("detect after quiet", sig_det, 1'b0);
        $display("rx_data done");
    endtask

    // Reset for 8 cycles, run every scenario, report
    initial begin
        repeat (8) @(posedge i_mclk);
        i_rst <= 1'b0;
        frame_normal();
        frame_error();
        rx_pulses();
        rx_data();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
